/* common/loop_coef_regs.svh */
// Constants for the loop filter coefficient decoder: field widths, exponent offsets, defaults
`ifndef LOOP_COEF_REGS_SVH
`define LOOP_COEF_REGS_SVH

// Field widths of the stored coefficient fields
`define ALPHA_MANT_W        16
`define ALPHA_SHIFT_W       6
`define ALPHA_FRONT_W       3
`define ALPHA_BACK_W        4
`define BETA_MANT_W         17
`define BETA_EXP_W          5
`define GAMMA_MANT_W        17
`define GAMMA_EXP_W         5
`define DELTA_MANT_W        15
`define DELTA_EXP_W         5

// Exponent offsets of the rebuilt coefficients
`define ALPHA_EXP_BASE      16
`define BETA_EXP_BASE       17
`define GAMMA_EXP_BASE      17
`define DELTA_EXP_BASE      15

// Feedback divider fields and the offset added to the stored integer value
`define FB_INT_W            30
`define FB_NUM_W            10
`define FB_DEN_W            10
`define FB_INT_OFFSET       1

// Widest mantissa, signed shift width, channel indices
`define COEF_MANT_MAX_W     17
`define COEF_SHIFT_W        8
`define COEF_NUM            4
`define CH_ALPHA            0
`define CH_BETA             1
`define CH_GAMMA            2
`define CH_DELTA            3

// Default output formats
`define COEF_W_DEF          64
`define COEF_FRAC_DEF       48
`define DIV_FRAC_DEF        16

`endif

/* common/loop_coef_pkg.sv */
// Types for the loop filter coefficient decoder
`include "loop_coef_regs.svh"

package loop_coef_pkg;

	// Stored coefficient fields as software writes them
	typedef struct packed {
		logic [`ALPHA_MANT_W-1:0]  alpha_mant;
		logic [`ALPHA_SHIFT_W-1:0] alpha_shift;
		logic [`ALPHA_FRONT_W-1:0] alpha_front;
		logic [`ALPHA_BACK_W-1:0]  alpha_back;
		logic [`BETA_MANT_W-1:0]   beta_mant;
		logic [`BETA_EXP_W-1:0]    beta_exp;
		logic [`GAMMA_MANT_W-1:0]  gamma_mant;
		logic [`GAMMA_EXP_W-1:0]   gamma_exp;
		logic [`DELTA_MANT_W-1:0]  delta_mant;
		logic [`DELTA_EXP_W-1:0]   delta_exp;
	} coef_fields_s;

	// Stored feedback divider values
	typedef struct packed {
		logic [`FB_INT_W-1:0] int_val;
		logic [`FB_NUM_W-1:0] num;
		logic [`FB_DEN_W-1:0] den;
	} fb_div_s;

	// Decoder sequence, one-hot
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SCALE  = 4'b0010,
		ST_DIVIDE = 4'b0100,
		ST_DONE   = 4'b1000
	} codec_state_e;

endpackage : loop_coef_pkg

/* rtl/coef_scaler.sv */
// Mantissa times signed power of two, with optional negation and saturation
`timescale 1ns/1ps

module coef_scaler #(
	parameter int MANT_W  = 17,
	parameter int SHIFT_W = 8,
	parameter int COEF_W  = 64
) (
	input  wire logic [MANT_W-1:0]         mant,
	input  wire logic signed [SHIFT_W-1:0] shift,
	input  wire logic                      negate,
	output logic signed [COEF_W-1:0]       coef,
	output logic                           sat
);

	localparam int WW = 2 * COEF_W;

	logic signed [WW-1:0]  base;
	logic signed [WW-1:0]  shifted;
	logic [SHIFT_W-1:0]    mag;
	logic                  too_far;
	logic                  ovf;

	// Signed mantissa first, then an arithmetic shift; left shifts are exact, right shifts round toward minus infinity
	always_comb begin
		base    = negate ? -$signed({{(WW-MANT_W){1'b0}}, mant}) : $signed({{(WW-MANT_W){1'b0}}, mant});
		mag     = shift[SHIFT_W-1] ? SHIFT_W'(-shift) : SHIFT_W'(shift);
		too_far = !shift[SHIFT_W-1] && (int'(mag) >= COEF_W) && (mant != '0);
		if (!shift[SHIFT_W-1]) begin
			shifted = base <<< mag;
		end else begin
			shifted = base >>> mag;
		end
		// Bits above the sign position must all match the sign
		ovf = (shifted[WW-1:COEF_W-1] != '0) && (shifted[WW-1:COEF_W-1] != '1);
		sat = too_far || ovf;
		if (sat) begin
			coef = negate ? {1'b1, {(COEF_W-1){1'b0}}} : {1'b0, {(COEF_W-1){1'b1}}};
		end else begin
			coef = shifted[COEF_W-1:0];
		end
	end

endmodule : coef_scaler

/* rtl/loop_filter_coefficient_codec.sv */
// Rebuilds loop filter coefficients and the feedback ratio from their stored fields
//
// Behaviour
// - Alpha equals mantissa times two^-(16+shift-front-back).
// - Alpha shift field moves binary point leftward.
// - Beta and gamma stored positive, negated internally.
// - Beta equals mantissa times two^-(17+exponent).
// - Gamma equals mantissa times two^-(17+exponent).
// - Delta equals mantissa times two^-(15+exponent), positive.
// - Divide ratio is stored integer plus one plus fraction.
`timescale 1ns/1ps
`include "loop_coef_regs.svh"

module loop_filter_coefficient_codec #(
	parameter int COEF_W    = `COEF_W_DEF,
	parameter int COEF_FRAC = `COEF_FRAC_DEF,
	parameter int DIV_FRAC  = `DIV_FRAC_DEF
) (
	input  wire logic                                  clk,
	input  wire logic                                  rst_n,
	input  wire logic                                  load,
	input  wire loop_coef_pkg::coef_fields_s           fields,
	input  wire loop_coef_pkg::fb_div_s                fb_div,
	output logic                                       busy,
	output logic                                       update_done,
	output logic signed [COEF_W-1:0]                   alpha_coef,
	output logic signed [COEF_W-1:0]                   beta_coef,
	output logic signed [COEF_W-1:0]                   gamma_coef,
	output logic signed [COEF_W-1:0]                   delta_coef,
	output logic [`COEF_NUM-1:0]                       coef_sat,
	output logic [`COEF_NUM-1:0]                       mant_zero,
	output logic [`FB_INT_W+DIV_FRAC+1:0]              fb_ratio,
	output logic                                       den_zero
);

	localparam int NUM_W   = `FB_NUM_W + DIV_FRAC;
	localparam int RATIO_W = `FB_INT_W + DIV_FRAC + 2;
	localparam int CNT_W   = $clog2(NUM_W + 1);

	loop_coef_pkg::codec_state_e                 state_q;
	loop_coef_pkg::codec_state_e                 state_d;
	loop_coef_pkg::coef_fields_s                 fields_q;
	loop_coef_pkg::fb_div_s                      fb_div_q;

	logic [`COEF_MANT_MAX_W-1:0]                 ch_mant   [`COEF_NUM];
	logic signed [`COEF_SHIFT_W-1:0]             ch_shift  [`COEF_NUM];
	logic                                        ch_neg    [`COEF_NUM];
	logic signed [COEF_W-1:0]                    ch_coef   [`COEF_NUM];
	logic                                        ch_sat    [`COEF_NUM];

	logic [NUM_W-1:0]                            dividend_q;
	logic [NUM_W-1:0]                            quot_q;
	logic [`FB_DEN_W:0]                          rem_q;
	logic [`FB_DEN_W:0]                          rem_trial;
	logic [CNT_W-1:0]                            cnt_q;
	logic [`FB_INT_W:0]                          int_ratio;

	// Sequence control; new loads are ignored until the current update completes
	always_comb begin
		state_d = state_q;
		case (state_q)
			loop_coef_pkg::ST_IDLE: begin
				if (load) begin
					state_d = loop_coef_pkg::ST_SCALE;
				end
			end
			loop_coef_pkg::ST_SCALE: begin
				if (fb_div_q.den == '0) begin
					state_d = loop_coef_pkg::ST_DONE;
				end else begin
					state_d = loop_coef_pkg::ST_DIVIDE;
				end
			end
			loop_coef_pkg::ST_DIVIDE: begin
				if (cnt_q == CNT_W'(1)) begin
					state_d = loop_coef_pkg::ST_DONE;
				end
			end
			loop_coef_pkg::ST_DONE: begin
				state_d = loop_coef_pkg::ST_IDLE;
			end
			default: begin
				state_d = loop_coef_pkg::ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= loop_coef_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign busy = (state_q != loop_coef_pkg::ST_IDLE);

	// Field capture; a snapshot keeps the decode stable while software rewrites ports
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fields_q <= '0;
			fb_div_q <= '0;
		end else if ((state_q == loop_coef_pkg::ST_IDLE) && load) begin
			fields_q <= fields;
			fb_div_q <= fb_div;
		end
	end

	// Per-channel mantissa, signed shift toward the output binary point, and sign
	always_comb begin
		ch_mant[`CH_ALPHA]  = `COEF_MANT_MAX_W'(fields_q.alpha_mant);
		// Shift field lowers the exponent, gains raise it; large shifts become right shifts
		ch_shift[`CH_ALPHA] = `COEF_SHIFT_W'(COEF_FRAC - `ALPHA_EXP_BASE
			- int'(fields_q.alpha_shift)
			+ int'(fields_q.alpha_front) + int'(fields_q.alpha_back));
		ch_neg[`CH_ALPHA]   = 1'b0;
		ch_mant[`CH_BETA]   = `COEF_MANT_MAX_W'(fields_q.beta_mant);
		ch_shift[`CH_BETA]  = `COEF_SHIFT_W'(COEF_FRAC - `BETA_EXP_BASE - int'(fields_q.beta_exp));
		ch_neg[`CH_BETA]    = 1'b1;
		ch_mant[`CH_GAMMA]  = `COEF_MANT_MAX_W'(fields_q.gamma_mant);
		ch_shift[`CH_GAMMA] = `COEF_SHIFT_W'(COEF_FRAC - `GAMMA_EXP_BASE - int'(fields_q.gamma_exp));
		ch_neg[`CH_GAMMA]   = 1'b1;
		ch_mant[`CH_DELTA]  = `COEF_MANT_MAX_W'(fields_q.delta_mant);
		ch_shift[`CH_DELTA] = `COEF_SHIFT_W'(COEF_FRAC - `DELTA_EXP_BASE - int'(fields_q.delta_exp));
		ch_neg[`CH_DELTA]   = 1'b0;
	end

	// One scaler per coefficient
	for (genvar i = 0; i < `COEF_NUM; i++) begin : g_ch
		coef_scaler #(
			.MANT_W  (`COEF_MANT_MAX_W),
			.SHIFT_W (`COEF_SHIFT_W),
			.COEF_W  (COEF_W)
		) u_scaler (
			.mant   (ch_mant[i]),
			.shift  (ch_shift[i]),
			.negate (ch_neg[i]),
			.coef   (ch_coef[i]),
			.sat    (ch_sat[i])
		);
	end

	// Coefficient outputs update together in the scale step
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alpha_coef <= '0;
			beta_coef  <= '0;
			gamma_coef <= '0;
			delta_coef <= '0;
		end else if (state_q == loop_coef_pkg::ST_SCALE) begin
			alpha_coef <= ch_coef[`CH_ALPHA];
			beta_coef  <= ch_coef[`CH_BETA];
			gamma_coef <= ch_coef[`CH_GAMMA];
			delta_coef <= ch_coef[`CH_DELTA];
		end
	end

	// Diagnostics: an encoder never stores a zero mantissa, so flag it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			coef_sat  <= '0;
			mant_zero <= '0;
		end else if (state_q == loop_coef_pkg::ST_SCALE) begin
			for (int k = 0; k < `COEF_NUM; k++) begin
				coef_sat[k]  <= ch_sat[k];
				mant_zero[k] <= (ch_mant[k] == '0);
			end
		end
	end

	// Restoring divider for the fractional part, one quotient bit per cycle
	assign rem_trial = {rem_q[`FB_DEN_W-1:0], dividend_q[NUM_W-1]};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dividend_q <= '0;
			quot_q     <= '0;
			rem_q      <= '0;
			cnt_q      <= '0;
		end else if (state_q == loop_coef_pkg::ST_SCALE) begin
			dividend_q <= {fb_div_q.num, {DIV_FRAC{1'b0}}};
			quot_q     <= '0;
			rem_q      <= '0;
			cnt_q      <= CNT_W'(NUM_W);
		end else if (state_q == loop_coef_pkg::ST_DIVIDE) begin
			dividend_q <= {dividend_q[NUM_W-2:0], 1'b0};
			cnt_q      <= cnt_q - CNT_W'(1);
			if (rem_trial >= {1'b0, fb_div_q.den}) begin
				rem_q  <= rem_trial - {1'b0, fb_div_q.den};
				quot_q <= {quot_q[NUM_W-2:0], 1'b1};
			end else begin
				rem_q  <= rem_trial;
				quot_q <= {quot_q[NUM_W-2:0], 1'b0};
			end
		end
	end

	// Stored integer value is one below the intended integer ratio
	assign int_ratio = {1'b0, fb_div_q.int_val} + (`FB_INT_W+1)'(`FB_INT_OFFSET);

	// Ratio and completion; a zero denominator drops the fraction and is flagged
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fb_ratio    <= '0;
			den_zero    <= 1'b0;
			update_done <= 1'b0;
		end else begin
			update_done <= (state_q == loop_coef_pkg::ST_DONE);
			if (state_q == loop_coef_pkg::ST_DONE) begin
				den_zero <= (fb_div_q.den == '0);
				if (fb_div_q.den == '0) begin
					fb_ratio <= RATIO_W'({int_ratio, {DIV_FRAC{1'b0}}});
				end else begin
					fb_ratio <= RATIO_W'({int_ratio, {DIV_FRAC{1'b0}}}) + RATIO_W'(quot_q);
				end
			end
		end
	end

endmodule : loop_filter_coefficient_codec

/* test/lfcc_checker.sv */
// Assertion checker for the loop filter coefficient decoder
`timescale 1ns/1ps
`include "loop_coef_regs.svh"

module lfcc_checker #(
	parameter int COEF_W    = 64,
	parameter int COEF_FRAC = 48,
	parameter int DIV_FRAC  = 16
) (
	input wire logic                         clk,
	input wire logic                         rst_n,
	input wire logic                         load,
	input wire loop_coef_pkg::coef_fields_s  fields,
	input wire loop_coef_pkg::fb_div_s       fb_div,
	input wire logic                         busy,
	input wire logic                         update_done,
	input wire logic signed [COEF_W-1:0]     alpha_coef,
	input wire logic signed [COEF_W-1:0]     beta_coef,
	input wire logic signed [COEF_W-1:0]     gamma_coef,
	input wire logic signed [COEF_W-1:0]     delta_coef,
	input wire logic [`COEF_NUM-1:0]         coef_sat,
	input wire logic [`COEF_NUM-1:0]         mant_zero,
	input wire logic [`FB_INT_W+DIV_FRAC+1:0] fb_ratio,
	input wire logic                         den_zero
);
	localparam int FW = `FB_INT_W + DIV_FRAC + 2;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	loop_coef_pkg::coef_fields_s f_q;
	loop_coef_pkg::fb_div_s      d_q;
	int                          a_sh;
	// Signed alpha shift toward the output binary point
	assign a_sh = COEF_FRAC - 16 - int'(f_q.alpha_shift) + int'(f_q.alpha_front) + int'(f_q.alpha_back);
	// Accepted request kept, so results can be tied to their cause
	always_ff @(posedge clk) begin
		if (load && !busy) begin
			f_q <= fields;
			d_q <= fb_div;
		end
	end
	sequence s_take; load && !busy; endsequence
	sequence s_done; update_done && !busy; endsequence
	property p_start; s_take |=> busy; endproperty
	property p_lat; s_take ##0 fb_div.den != '0 |-> ##29 s_done; endproperty
	property p_lat0; s_take ##0 fb_div.den == '0 |-> ##3 s_done; endproperty
	property p_pulse; update_done |=> !update_done; endproperty
	property p_alpha; update_done && !coef_sat[0] |-> alpha_coef == ((a_sh >= 0) ? COEF_W'(f_q.alpha_mant) << a_sh
		: COEF_W'(f_q.alpha_mant) >> (-a_sh)); endproperty
	property p_beta; update_done |-> beta_coef == -(COEF_W'(f_q.beta_mant) << (COEF_FRAC - 17 - f_q.beta_exp));
	endproperty
	property p_gamma; update_done |-> gamma_coef == -(COEF_W'(f_q.gamma_mant) << (COEF_FRAC - 17 - f_q.gamma_exp));
	endproperty
	property p_delta; update_done |-> delta_coef == COEF_W'(f_q.delta_mant) << (COEF_FRAC - 15 - f_q.delta_exp);
	endproperty
	property p_zero; update_done |-> mant_zero == {f_q.delta_mant == '0, f_q.gamma_mant == '0,
		f_q.beta_mant == '0, f_q.alpha_mant == '0}; endproperty
	property p_fb; update_done |-> den_zero == (d_q.den == '0) && fb_ratio == ((FW'(d_q.int_val) + 1) << DIV_FRAC)
		+ ((d_q.den == '0) ? FW'(0) : (FW'(d_q.num) << DIV_FRAC) / d_q.den); endproperty
	a_start: assert property (p_start) else $error("busy not raised after load");
	a_lat: assert property (p_lat) else $error("fractional update latency wrong");
	a_lat0: assert property (p_lat0) else $error("integer update latency wrong");
	a_pulse: assert property (p_pulse) else $error("update_done longer than one cycle");
	a_alpha: assert property (p_alpha) else $error("alpha value wrong");
	a_beta: assert property (p_beta) else $error("beta value wrong");
	a_gamma: assert property (p_gamma) else $error("gamma value wrong");
	a_delta: assert property (p_delta) else $error("delta value wrong");
	a_zero: assert property (p_zero) else $error("mant_zero flags wrong");
	a_fb: assert property (p_fb) else $error("feedback ratio wrong");
endmodule : lfcc_checker

bind loop_filter_coefficient_codec lfcc_checker #(.COEF_W(COEF_W), .COEF_FRAC(COEF_FRAC), .DIV_FRAC(DIV_FRAC)) u_chk (
	.clk, .rst_n, .load, .fields, .fb_div, .busy, .update_done, .alpha_coef, .beta_coef, .gamma_coef,
	.delta_coef, .coef_sat, .mant_zero, .fb_ratio, .den_zero);

/* test/test_loop_filter_coefficient_codec.sv */
// Self-checking bench for the loop filter coefficient decoder
`timescale 1ns/1ps

module test_loop_filter_coefficient_codec;
	logic                        clk, rst_n, load, busy, update_done, den_zero;
	loop_coef_pkg::coef_fields_s f;
	loop_coef_pkg::fb_div_s      d;
	logic signed [63:0]          a_c, b_c, g_c, d_c;
	logic [3:0]                  sat, mz;
	logic [47:0]                 fb;
	logic [159:0]                r;
	int                          n_errors = 0;
	int                          cmp_count = 0;

	loop_filter_coefficient_codec dut (.clk(clk), .rst_n(rst_n), .load(load), .fields(f), .fb_div(d),
		.busy(busy), .update_done(update_done), .alpha_coef(a_c), .beta_coef(b_c), .gamma_coef(g_c),
		.delta_coef(d_c), .coef_sat(sat), .mant_zero(mz), .fb_ratio(fb), .den_zero(den_zero));

	task automatic chk(string nm, logic [127:0] seen, logic [127:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic test_done();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	// One update; with a nonzero denominator, poke sends a load while busy that must be ignored
	task automatic run(bit poke);
		loop_coef_pkg::coef_fields_s sf;
		loop_coef_pkg::fb_div_s      sd;
		logic [127:0]                va;
		logic [47:0]                 ef;
		bit                          s;
		int                          n;
		int                          sh;
		sf = f;
		sd = d;
		load = 1;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			// Only touch load when it changes, so a following call may raise it in this step
			if (n == 1 || (poke && (n == 4 || n == 5)))
				load = poke && n == 4;
			if (n == 4)
				f = ~f;
		end while (!update_done && n < 40);
		sh = 32 - int'(sf.alpha_shift) + int'(sf.alpha_front) + int'(sf.alpha_back);
		va = (sh >= 0) ? 128'(sf.alpha_mant) << sh : 128'(sf.alpha_mant) >> (-sh);
		s = va > 128'h7fffffffffffffff; // Out of range saturates to max positive
		ef = ((48'(sd.int_val) + 1) << 16) + ((sd.den == '0) ? 48'h0 : (48'(sd.num) << 16) / sd.den);
		chk("latency", n, (sd.den == '0) ? 3 : 29);
		chk("busy", busy, 0);
		chk("alpha", a_c, s ? 64'h7fffffffffffffff : va[63:0]);
		chk("beta", b_c, -(64'(sf.beta_mant) << (31 - sf.beta_exp)));
		chk("gamma", g_c, -(64'(sf.gamma_mant) << (31 - sf.gamma_exp)));
		chk("delta", d_c, 64'(sf.delta_mant) << (33 - sf.delta_exp));
		chk("sat", sat, {3'h0, s});
		chk("zero", mz, {sf.delta_mant == '0, sf.gamma_mant == '0, sf.beta_mant == '0, sf.alpha_mant == '0});
		chk("ratio", {den_zero, fb}, {sd.den == '0, ef});
	endtask : run

	// Encoder side: exponent and mantissa of a magnitude, halves rounded up
	task automatic enc(input real v, input int base, input int emax, input int mmax, output int e, output int m);
		int x;
		x = -int'($ceil($ln(v) / $ln(2.0)));
		e = (x < 0) ? 0 : (x > emax) ? emax : x;
		x = int'($floor(v * (2.0 ** (base + e)) + 0.5));
		m = (x < 1) ? 1 : (x > mmax) ? mmax : x;
	endtask : enc

	// Coefficients from time constants, encoded; decoded values must land within quantization
	task automatic derive(input real fs, input real t1, input real t2, input real t3);
		loop_coef_pkg::coef_fields_s sf;
		real                         k, dr, wc, err;
		real                         c[4];
		real                         got[4];
		int                          g, e, m;
		k = 30517578125.0 / (2.0 ** 33) * fs;
		dr = real'(d.int_val) + 1.0 + real'(d.num) / real'(d.den);
		wc = 1.0 / $sqrt(t2 * (t1 + t3));
		c[0] = wc * wc * t2 * dr / (t1 * k)
			* $sqrt((1.0 + (wc * t1) ** 2) * (1.0 + (wc * t3) ** 2) / (1.0 + (wc * t2) ** 2));
		c[1] = 32.0 / fs * (1.0 / t1 + 1.0 / t2);
		c[2] = 32.0 / (fs * t1);
		c[3] = 32.0 / (fs * t3);
		g = (c[0] > 1.0) ? int'($ceil($ln(c[0]) / $ln(2.0))) : 0;
		g = (g > 22) ? 22 : g;
		enc(c[0], 16 - g, 63, 65535, e, m);
		sf.alpha_mant = 16'(m);
		sf.alpha_shift = 6'(e);
		sf.alpha_front = (g >= 8) ? 3'h7 : 3'(g);
		sf.alpha_back = (g >= 8) ? 4'(g - 7) : 4'h0;
		enc(c[1], 17, 31, 131071, e, m);
		sf.beta_mant = 17'(m);
		sf.beta_exp = 5'(e);
		enc(c[2], 17, 31, 131071, e, m);
		sf.gamma_mant = 17'(m);
		sf.gamma_exp = 5'(e);
		enc(c[3], 15, 31, 32767, e, m);
		sf.delta_mant = 15'(m);
		sf.delta_exp = 5'(e);
		f = sf;
		run(0);
		got[0] = real'(a_c);
		got[1] = -real'(b_c);
		got[2] = -real'(g_c);
		got[3] = real'(d_c);
		for (int i = 0; i < 4; i++) begin
			err = got[i] / (2.0 ** 48) - c[i];
			chk("near", ((err < 0.0) ? -err : err) <= c[i] / 16384.0, 1'b1);
		end
	endtask : derive

	// Free running 100 MHz clock
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	// Guard against a hung handshake
	initial begin
		#100000;
		n_errors++;
		test_done();
	end

	// Reset, worked example, extremes, then random back-to-back updates
	initial begin
		rst_n = 0;
		load = 0;
		f = '0;
		d = '0;
		void'($urandom(32'hce4f1214));
		repeat (2) @(posedge clk);
		#1;
		chk("reset", {busy, update_done, a_c, fb}, '0);
		rst_n = 1;
		f = {16'hd0a8, 6'h06, 3'h0, 4'h0, 17'h1250b, 5'h0d, 17'h13abb, 5'h0d, 15'h420a, 5'h08};
		d = {30'h9, 10'h3, 10'h7};
		run(0);
		// Small alpha, then alpha above one so the front gain is used
		derive(1.0e8, 1.0e-3, 1.0e-2, 1.0e-3);
		derive(1.0e5, 1.0e-3, 1.0e-2, 1.0e-3);
		f = {16'hffff, 6'h0, 3'h7, 4'hf, 17'h1ffff, 5'h0, 17'h1ffff, 5'h1f, 15'h7fff, 5'h0};
		d = {30'h3fffffff, 10'h3ff, 10'h1};
		run(1);
		f = '0;
		d = '0;
		run(0);
		for (int i = 0; i < 24; i++) begin
			r = {$urandom, $urandom, $urandom, $urandom, $urandom};
			// Alpha shift and denominator forced in the word, so each input is driven once
			if (i % 2)
				r[76:71] = 6'h3f;
			if (i % 3 == 0)
				r[102:93] = 10'h0;
			f = r[92:0];
			d = r[142:93];
			run(i % 4 == 1);
		end
		test_done();
	end
endmodule : test_loop_filter_coefficient_codec
